// ### include/lbm_pkg.sv
// Constants, encodings and timing for the stereo METER_SELECTOR_SWITCH bar meter mode controller.
// Assumes a 200 MHz system clock and a classic Wishbone register slave.
// Operation
// - Three-position selector: momentary down for mode/reset, middle peak view, up gain view.
// - Eight colours and four modes; middle or up position drives display per mode.
// - Down held over half a second enters menu; top two right segments pulse.
// - In menu the chosen mode shows as a segment flanked by two others, low right.
// - In menu each short down press advances the chosen mode.
// - Menu confirms after 2.5 s without a press or another long press.
// - Confirming modes 1 or 2 resumes metering; modes 3 or 4 show option displays.
// - Mode 1 peak view: green/amber level bar up, fast limiter red dot down.
// - Mode 1 gain view: fast limiter green bar down, optical orange dot down.
// - Mode 1 shows no peak-hold dot and no third bar colour.
// - Mode 2 peak view: peak meter with hold dot, green, amber and red zones.
// - Mode 2 gain view: sum of both limiters' gain reduction as bar from top.
// - Mode 3 lights the whole left bar; right bar keeps showing peak level.
// - Mode 3 trim sets green/amber point in middle, amber/red point when up.
// - Mode 4 left bar shows hold option: lowest none, middle one second, third infinite.
// - Infinite hold keeps dot until short press; clip indications are not held.
// - Every mode change writes all meter settings to non-volatile storage, except green/amber and amber/red points set by the same bus write.
// - Down held at power-up restores defaults, shows two red left, green right.
// - Switching gain view to peak view and back clears stuck optical segments.
// - Peak over converter clip turns the lit green segments of the peak bar red, but not the hold dot.
// - Short down press outside the menu clears the held peak dot.
package lbm_pkg;
	localparam int unsigned CLK_HZ        = 200_000_000;
	localparam int unsigned LONG_PRESS_MS = 500;
	localparam int unsigned CONFIRM_MS    = 2500;
	localparam int unsigned HOLD_ONE_MS   = 1000;
	localparam int unsigned LONG_PRESS_CYC = (CLK_HZ / 1000) * LONG_PRESS_MS;
	localparam int unsigned CONFIRM_CYC    = (CLK_HZ / 1000) * CONFIRM_MS;
	localparam int unsigned HOLD_ONE_CYC   = (CLK_HZ / 1000) * HOLD_ONE_MS;

	localparam logic [3:0] ADR_SETTINGS = 4'h0;
	localparam logic [3:0] ADR_STATUS   = 4'h4;
	localparam int MODE_LSB = 0;
	localparam int HOLD_LSB = 2;
	localparam int GA_LSB   = 8;
	localparam int AR_LSB   = 16;

	localparam logic [1:0] MODE_DUAL   = 2'h0;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [1:0] MODE_COLOR  = 2'h2;
	localparam logic [1:0] MODE_HOLD   = 2'h3;
	localparam logic [1:0] HOLD_NONE   = 2'h0;
	localparam logic [1:0] HOLD_ONE    = 2'h1;
	localparam logic [1:0] HOLD_INF    = 2'h2;

	localparam logic [1:0] DEF_MODE = MODE_SINGLE;
	localparam logic [1:0] DEF_HOLD = HOLD_ONE;
	localparam logic [7:0] DEF_GA   = 8'h0a;
	localparam logic [7:0] DEF_AR   = 8'h0d;

	localparam int unsigned BLINK_MSB = 23;

	typedef enum logic [2:0]
	{
		COL_OFF    = 3'h0,
		COL_GREEN  = 3'h1,
		COL_AMBER  = 3'h2,
		COL_RED    = 3'h3,
		COL_ORANGE = 3'h4,
		COL_YELLOW = 3'h5,
		COL_BLUE   = 3'h6,
		COL_WHITE  = 3'h7
	} lbm_color_t;

	typedef enum logic [3:0]
	{
		ST_BOOT    = 4'h1,
		ST_DEFAULT = 4'h2,
		ST_RUN     = 4'h4,
		ST_MENU    = 4'h8
	} lbm_state_t;
endpackage : lbm_pkg

// ### design/lbm_mode_controller.sv
// Mode controller and segment composer for a stereo METER_SELECTOR_SWITCH bar meter.
// Assumes synchronous selector, trim and level inputs; levels are lit-segment counts.
`timescale 1ns/1ps
`default_nettype none
module lbm_mode_controller
	import lbm_pkg::*;
#(
	parameter int unsigned NSEG         = 16,
	parameter int unsigned LW           = 8,
	parameter int unsigned LONG_CYC     = LONG_PRESS_CYC,
	parameter int unsigned CONF_CYC     = CONFIRM_CYC,
	parameter int unsigned HOLD_CYC     = HOLD_ONE_CYC
)
(
	input  wire logic                 clk_sys,
	input  wire logic                 srst,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [3:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	input  wire logic                 selDown,
	input  wire logic                 selUp,
	input  wire logic [LW-1:0]        trimPot,
	input  wire logic [1:0][LW-1:0]   peakLevel,
	input  wire logic [1:0][LW-1:0]   fastLimiterDepth,
	input  wire logic [1:0][LW-1:0]   opticalDepth,
	input  wire logic [1:0]           clipIn,
	input  wire logic [31:0]          nvmLoadData,
	output logic                      nvmSaveStb,
	output logic      [31:0]          nvmSaveData,
	output logic [NSEG-1:0][2:0]      leftColor,
	output logic [NSEG-1:0][2:0]      rightColor
);
	lbm_state_t              state_reg, state_next;
	logic [1:0]              mode_reg, mode_next;
	logic [1:0]              menuMode_reg, menuMode_next;
	logic [1:0]              hold_reg, hold_next;
	logic [7:0]              ga_reg, ga_next;
	logic [7:0]              ar_reg, ar_next;
	logic [31:0]             press_reg, press_next;
	logic [31:0]             menuTmr_reg, menuTmr_next;
	logic [1:0][31:0]        holdTmr_reg, holdTmr_next;
	logic [1:0][LW-1:0]      peakHeld_reg, peakHeld_next;
	logic [1:0][LW-1:0]      opticalDot_reg, opticalDot_next;
	logic [BLINK_MSB:0]      blink_reg, blink_next;
	logic                    ack_reg, ack_next;
	logic [31:0]             rdat_reg, rdat_next;
	logic                    save_reg, save_next;
	logic [31:0]             saveDat_reg, saveDat_next;
	logic                    defDone_reg, defDone_next;
	logic [NSEG-1:0][2:0]    left_reg, left_next;
	logic [NSEG-1:0][2:0]    right_reg, right_next;
	logic                    shortPress;
	logic                    longPress;
	logic                    viewGain;
	logic                    busReq;
	logic [31:0]             settingsWord;

	function automatic logic [31:0] packSettings(input logic [1:0] m, input logic [1:0] h,
		input logic [7:0] g, input logic [7:0] a);
		packSettings = {8'h00, a, g, 4'h0, h, m};
	endfunction : packSettings

	function automatic logic fromTop(input int unsigned i, input logic [LW-1:0] v);
		fromTop = (NSEG - 1 - i) < int'(v);
	endfunction : fromTop

	function automatic lbm_color_t zoneColor(input int unsigned i, input logic [7:0] g,
		input logic [7:0] a, input logic three, input logic clip);
		if (i < int'(g))
			zoneColor = clip ? COL_RED : COL_GREEN;
		else if (!three || i < int'(a))
			zoneColor = COL_AMBER;
		else
			zoneColor = COL_RED;
	endfunction : zoneColor

	assign viewGain     = selUp && !selDown;
	assign busReq       = wb_cyc_i && wb_stb_i && !ack_reg;
	assign settingsWord = packSettings(mode_reg, hold_reg, ga_reg, ar_reg);
	assign longPress    = selDown && press_reg == LONG_CYC - 1;
	assign shortPress   = !selDown && press_reg != 32'h0 && press_reg < LONG_CYC;

	// Selector timing, mode menu, settings and bus slave
	always_comb
	begin
		state_next    = state_reg;
		mode_next     = mode_reg;
		menuMode_next = menuMode_reg;
		hold_next     = hold_reg;
		ga_next       = ga_reg;
		ar_next       = ar_reg;
		defDone_next  = defDone_reg;
		save_next     = 1'b0;
		saveDat_next  = saveDat_reg;
		press_next    = selDown ? press_reg + 32'h1 : 32'h0;
		if (press_reg == 32'hffff_ffff && selDown)
			press_next = press_reg;
		menuTmr_next  = (selDown || state_reg != ST_MENU) ? 32'h0 : menuTmr_reg + 32'h1;
		blink_next    = blink_reg + 1'b1;
		ack_next      = busReq;
		rdat_next     = 32'h0;
		unique case (state_reg)
			ST_BOOT:
			begin
				if (selDown)
				begin
					state_next   = ST_DEFAULT;
					mode_next    = DEF_MODE;
					hold_next    = DEF_HOLD;
					ga_next      = DEF_GA;
					ar_next      = DEF_AR;
					defDone_next = 1'b1;
					save_next    = 1'b1;
					saveDat_next = packSettings(DEF_MODE, DEF_HOLD, DEF_GA, DEF_AR);
				end
				else
				begin
					state_next = ST_RUN;
					mode_next  = nvmLoadData[MODE_LSB +: 2];
					hold_next  = nvmLoadData[HOLD_LSB +: 2];
					ga_next    = nvmLoadData[GA_LSB +: 8];
					ar_next    = nvmLoadData[AR_LSB +: 8];
				end
			end
			ST_DEFAULT:
				if (!selDown)
					state_next = ST_RUN;
			ST_RUN:
			begin
				if (longPress)
				begin
					state_next    = ST_MENU;
					menuMode_next = mode_reg;
				end
				else if (shortPress && mode_reg == MODE_HOLD)
					hold_next = (hold_reg >= HOLD_INF) ? HOLD_NONE : hold_reg + 2'h1;
				if (mode_reg == MODE_COLOR)
				begin
					if (viewGain)
						ar_next = 8'(trimPot);
					else if (!selDown)
						ga_next = 8'(trimPot);
				end
			end
			ST_MENU:
			begin
				if (shortPress)
					menuMode_next = menuMode_reg + 2'h1;
				if (longPress || menuTmr_reg == CONF_CYC - 1)
				begin
					state_next   = ST_RUN;
					mode_next    = menuMode_reg;
					save_next    = 1'b1;
					saveDat_next = packSettings(menuMode_reg, hold_reg, ga_reg, ar_reg);
				end
			end
		endcase
		if (busReq && wb_we_i && wb_adr_i == ADR_SETTINGS && state_reg == ST_RUN)
		begin
			if (wb_sel_i[0])
			begin
				mode_next = wb_dat_i[MODE_LSB +: 2];
				hold_next = wb_dat_i[HOLD_LSB +: 2];
				if (wb_dat_i[MODE_LSB +: 2] != mode_reg)
				begin
					save_next    = 1'b1;
					saveDat_next = packSettings(wb_dat_i[MODE_LSB +: 2], wb_dat_i[HOLD_LSB +: 2],
						ga_next, ar_next);
				end
			end
			if (wb_sel_i[1])
				ga_next = wb_dat_i[GA_LSB +: 8];
			if (wb_sel_i[2])
				ar_next = wb_dat_i[AR_LSB +: 8];
		end
		if (busReq && !wb_we_i)
		begin
			if (wb_adr_i == ADR_SETTINGS)
				rdat_next = settingsWord;
			else if (wb_adr_i == ADR_STATUS)
				rdat_next = {16'h0, 8'(peakHeld_reg[0]), 1'b0, defDone_reg, viewGain,
					menuMode_reg, state_reg[2:0]};
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			state_reg    <= ST_BOOT;
			mode_reg     <= DEF_MODE;
			menuMode_reg <= DEF_MODE;
			hold_reg     <= DEF_HOLD;
			ga_reg       <= DEF_GA;
			ar_reg       <= DEF_AR;
			press_reg    <= 32'h0;
			menuTmr_reg  <= 32'h0;
			blink_reg    <= '0;
			ack_reg      <= 1'b0;
			rdat_reg     <= 32'h0;
			save_reg     <= 1'b0;
			saveDat_reg  <= 32'h0;
			defDone_reg  <= 1'b0;
		end
		else
		begin
			state_reg    <= state_next;
			mode_reg     <= mode_next;
			menuMode_reg <= menuMode_next;
			hold_reg     <= hold_next;
			ga_reg       <= ga_next;
			ar_reg       <= ar_next;
			press_reg    <= press_next;
			menuTmr_reg  <= menuTmr_next;
			blink_reg    <= blink_next;
			ack_reg      <= ack_next;
			rdat_reg     <= rdat_next;
			save_reg     <= save_next;
			saveDat_reg  <= saveDat_next;
			defDone_reg  <= defDone_next;
		end
	end

	// Peak hold and optical dot memory per channel
	always_comb
	begin
		peakHeld_next   = peakHeld_reg;
		holdTmr_next    = holdTmr_reg;
		opticalDot_next = opticalDot_reg;
		for (int c = 0; c < 2; c++)
		begin
			holdTmr_next[c] = holdTmr_reg[c] + 32'h1;
			if (hold_reg == HOLD_NONE || (hold_reg == HOLD_ONE && holdTmr_reg[c] >= HOLD_CYC - 1))
			begin
				peakHeld_next[c] = peakLevel[c];
				holdTmr_next[c]  = 32'h0;
			end
			else if (peakLevel[c] > peakHeld_reg[c])
			begin
				peakHeld_next[c] = peakLevel[c];
				holdTmr_next[c]  = 32'h0;
			end
			if (shortPress && state_reg == ST_RUN)
			begin
				peakHeld_next[c] = peakLevel[c];
				holdTmr_next[c]  = 32'h0;
			end
			if (!viewGain)
				opticalDot_next[c] = '0;
			else if (opticalDepth[c] > opticalDot_reg[c])
				opticalDot_next[c] = opticalDepth[c];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			peakHeld_reg   <= '0;
			holdTmr_reg    <= '0;
			opticalDot_reg <= '0;
		end
		else
		begin
			peakHeld_reg   <= peakHeld_next;
			holdTmr_reg    <= holdTmr_next;
			opticalDot_reg <= opticalDot_next;
		end
	end

	// Segment composer
	always_comb
	begin
		logic [1:0][2:0] seg;
		logic [LW:0]     depthSum;
		seg        = '0;
		depthSum   = '0;
		left_next  = '0;
		right_next = '0;
		for (int unsigned i = 0; i < NSEG; i++)
		begin
			for (int c = 0; c < 2; c++)
			begin
				seg[c] = COL_OFF;
				depthSum = {1'b0, fastLimiterDepth[c]} + {1'b0, opticalDepth[c]};
				if (mode_reg == MODE_DUAL && viewGain)
				begin
					if (fromTop(i, fastLimiterDepth[c]))
						seg[c] = COL_GREEN;
					if (opticalDot_reg[c] != '0 && (NSEG - i) == int'(opticalDot_reg[c]))
						seg[c] = COL_ORANGE;
				end
				else if (mode_reg == MODE_SINGLE && viewGain)
				begin
					if ((NSEG - 1 - i) < int'(depthSum))
						seg[c] = COL_GREEN;
				end
				else
				begin
					if (i < int'(peakLevel[c]))
						seg[c] = zoneColor(i, ga_reg, ar_reg, mode_reg != MODE_DUAL,
							clipIn[c]);
					if (mode_reg == MODE_SINGLE && peakHeld_reg[c] != '0
						&& hold_reg != HOLD_NONE && i == int'(peakHeld_reg[c]) - 1)
						seg[c] = zoneColor(i, ga_reg, ar_reg, 1'b1, 1'b0);
					if (mode_reg == MODE_DUAL && fastLimiterDepth[c] != '0
						&& (NSEG - i) == int'(fastLimiterDepth[c]))
						seg[c] = COL_RED;
				end
			end
			left_next[i]  = seg[0];
			right_next[i] = seg[1];
			if (mode_reg == MODE_COLOR)
				left_next[i] = zoneColor(i, ga_reg, ar_reg, 1'b1, 1'b0);
			else if (mode_reg == MODE_HOLD)
				left_next[i] = (i == int'(hold_reg) && i < 3) ? COL_WHITE : COL_OFF;
			if (state_reg == ST_MENU)
			begin
				left_next[i]  = COL_OFF;
				right_next[i] = COL_OFF;
				if (i >= NSEG - 2)
					right_next[i] = blink_reg[BLINK_MSB -: 3];
				if (i == int'(menuMode_reg) + 2)
					right_next[i] = COL_WHITE;
				else if (i == int'(menuMode_reg) + 1 || i == int'(menuMode_reg) + 3)
					right_next[i] = COL_BLUE;
			end
			else if (state_reg == ST_DEFAULT || state_reg == ST_BOOT)
			begin
				left_next[i]  = (i < 2 && state_reg == ST_DEFAULT) ? COL_RED : COL_OFF;
				right_next[i] = (i < 2 && state_reg == ST_DEFAULT) ? COL_GREEN : COL_OFF;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			left_reg  <= '0;
			right_reg <= '0;
		end
		else
		begin
			left_reg  <= left_next;
			right_reg <= right_next;
		end
	end

	assign wb_ack_o    = ack_reg;
	assign wb_dat_o    = rdat_reg;
	assign nvmSaveStb  = save_reg;
	assign nvmSaveData = saveDat_reg;
	assign leftColor   = left_reg;
	assign rightColor  = right_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	bus_ack_a: assert property (busReq |=> wb_ack_o ##1 !wb_ack_o)
		else $error("Ack not one cycle after request");
	menu_enter_a: assert property ((state_reg == ST_RUN && longPress) |=> state_reg == ST_MENU)
		else $error("Long press did not open menu");
	menu_pulse_a: assert property (state_reg == ST_MENU |=>
		right_reg[NSEG-1] == $past(blink_reg[BLINK_MSB -: 3]))
		else $error("Menu pulse missing");
	menu_wrap_a: assert property ((state_reg == ST_MENU && shortPress
		&& menuMode_reg == MODE_HOLD) |=> menuMode_reg == MODE_DUAL)
		else $error("Menu did not wrap");
	menu_adv_a: assert property ((state_reg == ST_MENU && shortPress && !longPress)
		|=> menuMode_reg == $past(menuMode_reg) + 2'h1)
		else $error("Menu did not advance");
	menu_timeout_a: assert property ((state_reg == ST_MENU && !selDown
		&& menuTmr_reg == CONF_CYC - 1) |=> state_reg == ST_RUN && nvmSaveStb
		&& mode_reg == $past(menuMode_reg))
		else $error("Menu timeout did not confirm");
	save_data_a: assert property ((state_reg == ST_MENU && longPress)
		|=> nvmSaveStb && nvmSaveData[MODE_LSB +: 2] == mode_reg)
		else $error("Save missing on mode change");
	trim_ga_a: assert property ((state_reg == ST_RUN && mode_reg == MODE_COLOR && !selDown
		&& !selUp && !longPress && !busReq) |=> ga_reg == $past(8'(trimPot)))
		else $error("Trim not applied");
	peak_clear_a: assert property ((state_reg == ST_RUN && shortPress)
		|=> peakHeld_reg[0] == $past(peakLevel[0]))
		else $error("Held peak not cleared");
	default_show_a: assert property (state_reg == ST_DEFAULT |=>
		state_reg != ST_DEFAULT || (left_reg[0] == COL_RED && right_reg[1] == COL_GREEN))
		else $error("Default acknowledge display wrong");
	optical_clear_a: assert property (!viewGain |=> opticalDot_reg == '0)
		else $error("Optical dot not cleared");

	enter_menu_c: cover property (state_reg == ST_RUN ##1 state_reg == ST_MENU);
	wrap_c: cover property (state_reg == ST_MENU && shortPress && menuMode_reg == MODE_HOLD);
	defaults_c: cover property (state_reg == ST_DEFAULT ##1 state_reg == ST_RUN);
	save_c: cover property (nvmSaveStb);
endmodule : lbm_mode_controller
`default_nettype wire

// ### tb/lbm_panel_model.sv
// Front-panel model: meter selector toggle and trim potentiometer.
// Assumes the bench calls its tasks right after a rising edge of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module lbm_panel_model
	import lbm_pkg::*;
(
	input  wire logic       clk_sys,
	output var  logic       selDown,
	output var  logic       selUp,
	output var  logic [7:0] trimPot
);
	// Down held from power-up to ask for the defaults
	initial
	begin
		selDown = 1'b1;
		selUp   = 1'b0;
		trimPot = 8'h80;
	end

	// Spring position held for n cycles, then released
	task automatic press(input int n);
		selDown <= 1'b1;
		repeat (n) @(posedge clk_sys);
		selDown <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask : press

	// Operator lets go once the bars acknowledge
	task automatic letGo();
		selDown <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask : letGo

	task automatic view(input logic up, input logic [7:0] trim);
		selUp   <= up;
		trimPot <= trim;
		repeat (4) @(posedge clk_sys);
	endtask : view
endmodule : lbm_panel_model
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the bar meter mode controller.
// Assumes the panel model drives the selector and trim inputs.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import lbm_pkg::*;
;
	logic             clk_sys;
	logic             srst;
	logic             wbCyc;
	logic             wbStb;
	logic             wbWe;
	logic [3:0]       wbAdr;
	logic [3:0]       wbSel;
	logic [31:0]      wbDatW;
	logic [31:0]      wbDatR;
	logic             wbAck;
	wire  logic       selDown;
	wire  logic       selUp;
	wire  logic [7:0] trimPot;
	logic [1:0][7:0]  peakLevel;
	logic [1:0][7:0]  fastDepth;
	logic [1:0][7:0]  optDepth;
	logic [1:0]       clipIn;
	logic [31:0]      nvmLoad;
	logic [31:0]      nvmSave;
	logic             nvmStb;
	logic [15:0][2:0] leftCol;
	logic [15:0][2:0] rightCol;
	logic [31:0]      rd;
	int               nMismatch = 0;
	int               cmpCount = 0;
	int               saveCount = 0;

	lbm_mode_controller #(.LONG_CYC(20), .CONF_CYC(100), .HOLD_CYC(40)) u_dut
	(
		.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
		.wb_dat_o(wbDatR), .wb_ack_o(wbAck), .selDown(selDown), .selUp(selUp),
		.trimPot(trimPot), .peakLevel(peakLevel), .fastLimiterDepth(fastDepth),
		.opticalDepth(optDepth), .clipIn(clipIn), .nvmLoadData(nvmLoad),
		.nvmSaveStb(nvmStb), .nvmSaveData(nvmSave), .leftColor(leftCol),
		.rightColor(rightCol)
	);

	lbm_panel_model u_panel
	(
		.clk_sys(clk_sys), .selDown(selDown), .selUp(selUp), .trimPot(trimPot)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
		if (nvmStb === 1'b1)
			saveCount <= saveCount + 1;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp)
		begin
			nMismatch++;
			$display("CHECK FAILED t=%0t value mismatch got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic sc(input logic right, input int i, input logic [2:0] e);
		chk({29'h0, right ? rightCol[i] : leftCol[i]}, {29'h0, e});
	endtask : sc

	task automatic nz(input logic [2:0] c);
		chk({31'h0, c !== COL_OFF}, 32'h1);
	endtask : nz

	function automatic logic [31:0] cnt(input logic [15:0][2:0] b, input logic [2:0] c);
		cnt = 32'h0;
		for (int i = 0; i < 16; i++)
			cnt += (b[i] === c) ? 32'h1 : 32'h0;
	endfunction : cnt

	// One classic cycle; held until ack is sampled high
	task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
		input logic [31:0] d);
		wbCyc  <= 1'b1;
		wbStb  <= 1'b1;
		wbWe   <= we;
		wbAdr  <= adr;
		wbSel  <= sel;
		wbDatW <= d;
		do
			@(posedge clk_sys);
		while (wbAck !== 1'b1);
		rd = wbDatR;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge clk_sys);
	endtask : wb

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick

	task automatic end_sim();
		$display("mismatches %0d compares %0d", nMismatch, cmpCount);
		if (nMismatch == 0 && cmpCount > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	initial
	begin
		#300000;
		nMismatch++;
		end_sim();
	end

	initial
	begin
		srst = 1'b1;
		wbCyc = 1'b0;
		wbStb = 1'b0;
		wbWe = 1'b0;
		wbAdr = 4'h0;
		wbSel = 4'h0;
		wbDatW = 32'h0;
		peakLevel = '0;
		fastDepth = '0;
		optDepth = '0;
		clipIn = 2'h0;
		nvmLoad = 32'h0;
		tick(16);
		srst <= 1'b0;
		tick(6);
		chk(cnt(leftCol, COL_RED), 32'h2);
		chk(cnt(rightCol, COL_GREEN), 32'h2);
		chk(32'(saveCount), 32'h1);
		u_panel.letGo();
		wb(1'b0, ADR_SETTINGS, 4'h0, 32'h0);
		chk(rd, {8'h0, DEF_AR, DEF_GA, 4'h0, DEF_HOLD, DEF_MODE});
		// Second reset loads the stored word
		nvmLoad <= 32'h0009_0509;
		srst <= 1'b1;
		tick(2);
		srst <= 1'b0;
		tick(3);
		wb(1'b0, ADR_SETTINGS, 4'h0, 32'h0);
		chk(rd, 32'h0009_0509);
		peakLevel[0] <= 8'h0a;
		tick(6);
		peakLevel[0] <= 8'h03;
		tick(100);
		wb(1'b0, ADR_STATUS, 4'h0, 32'h0);
		chk({24'h0, rd[15:8]}, 32'h0a);
		sc(1'b0, 9, COL_RED);
		sc(1'b0, 5, COL_OFF);
		u_panel.press(3);
		wb(1'b0, ADR_STATUS, 4'h0, 32'h0);
		chk({24'h0, rd[15:8]}, 32'h03);
		wb(1'b1, ADR_SETTINGS, 4'h7, 32'h0008_0401);
		peakLevel[1] <= 8'h0c;
		tick(4);
		sc(1'b1, 1, COL_GREEN);
		sc(1'b1, 6, COL_AMBER);
		sc(1'b1, 10, COL_RED);
		sc(1'b1, 13, COL_OFF);
		sc(1'b0, 2, COL_GREEN);
		sc(1'b0, 3, COL_OFF);
		fastDepth <= {8'h02, 8'h01};
		optDepth <= {8'h03, 8'h00};
		u_panel.view(1'b1, 8'h80);
		sc(1'b1, 11, COL_GREEN);
		sc(1'b1, 10, COL_OFF);
		sc(1'b0, 15, COL_GREEN);
		sc(1'b0, 14, COL_OFF);
		u_panel.view(1'b0, 8'h80);
		wb(1'b1, ADR_SETTINGS, 4'h1, 32'h0);
		tick(2);
		chk(32'(saveCount), 32'h2);
		chk(nvmSave, 32'h0008_0400);
		wb(1'b0, 4'h8, 4'h0, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, ADR_STATUS, 4'hf, 32'hffff_ffff);
		wb(1'b0, ADR_STATUS, 4'h0, 32'h0);
		chk({29'h0, rd[2:0]}, 32'h4);
		fastDepth <= {8'h03, 8'h04};
		tick(4);
		sc(1'b1, 2, COL_GREEN);
		sc(1'b1, 10, COL_AMBER);
		sc(1'b1, 12, COL_OFF);
		sc(1'b1, 13, COL_RED);
		sc(1'b0, 12, COL_RED);
		clipIn <= 2'h3;
		tick(4);
		sc(1'b1, 2, COL_RED);
		sc(1'b1, 10, COL_AMBER);
		sc(1'b0, 0, COL_RED);
		clipIn <= 2'h0;
		fastDepth <= {8'h02, 8'h01};
		optDepth <= {8'h05, 8'h06};
		u_panel.view(1'b1, 8'h80);
		sc(1'b1, 15, COL_GREEN);
		sc(1'b1, 11, COL_ORANGE);
		sc(1'b0, 15, COL_GREEN);
		sc(1'b0, 10, COL_ORANGE);
		optDepth <= '0;
		tick(4);
		sc(1'b1, 11, COL_ORANGE);
		sc(1'b0, 10, COL_ORANGE);
		u_panel.view(1'b0, 8'h80);
		u_panel.view(1'b1, 8'h80);
		sc(1'b1, 11, COL_OFF);
		sc(1'b0, 10, COL_OFF);
		u_panel.view(1'b0, 8'h80);
		// Menu entry, scrolling with wrap, timed confirm
		u_panel.press(25);
		wb(1'b0, ADR_STATUS, 4'h0, 32'h0);
		chk({27'h0, rd[4:0]}, 32'h0);
		sc(1'b1, 2, COL_WHITE);
		sc(1'b1, 1, COL_BLUE);
		repeat (3) u_panel.press(3);
		wb(1'b0, ADR_STATUS, 4'h0, 32'h0);
		chk({30'h0, rd[4:3]}, 32'h3);
		u_panel.press(3);
		wb(1'b0, ADR_STATUS, 4'h0, 32'h0);
		chk({30'h0, rd[4:3]}, 32'h0);
		repeat (2) u_panel.press(3);
		tick(110);
		wb(1'b0, ADR_SETTINGS, 4'h0, 32'h0);
		chk({30'h0, rd[1:0]}, 32'h2);
		chk(32'(saveCount), 32'h3);
		nz(leftCol[0]);
		nz(leftCol[15]);
		sc(1'b1, 2, COL_GREEN);
		u_panel.view(1'b0, 8'h07);
		u_panel.view(1'b1, 8'h09);
		wb(1'b0, ADR_SETTINGS, 4'h0, 32'h0);
		chk({16'h0, rd[23:8]}, 32'h0907);
		u_panel.view(1'b0, 8'h07);
		// Confirm by a second long press
		u_panel.press(25);
		u_panel.press(3);
		u_panel.press(25);
		wb(1'b0, ADR_SETTINGS, 4'h0, 32'h0);
		chk({28'h0, rd[3:0]}, 32'h3);
		sc(1'b0, 0, COL_WHITE);
		u_panel.press(3);
		wb(1'b0, ADR_SETTINGS, 4'h0, 32'h0);
		chk({30'h0, rd[3:2]}, 32'h1);
		sc(1'b0, 1, COL_WHITE);
		sc(1'b0, 0, COL_OFF);
		// One-second hold keeps a peak, then lets it fall
		peakLevel[0] <= 8'h0b;
		tick(2);
		peakLevel[0] <= 8'h02;
		tick(10);
		wb(1'b0, ADR_STATUS, 4'h0, 32'h0);
		chk({24'h0, rd[15:8]}, 32'h0b);
		tick(50);
		wb(1'b0, ADR_STATUS, 4'h0, 32'h0);
		chk({24'h0, rd[15:8]}, 32'h02);
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
